// file: rtl/port_io.sv
// 8-bit port data and direction registers behind an ahb-lite slave
// Behaviour
// - output pin drives its data bit when its drive pair selects cmos
// - input pin read returns live level
// - written data value reads back on output pins only
// - bit 0 is low, 1 is high
// - direction bit n: 0 output, 1 input
// - data register byte-wide, resets to zero
// - direction register resets zero, all outputs
// - drive bytes also reachable as 16-bit word
// - drive pair picks pad state per pin
module port_io
(
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire port_pkg::word_t haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire port_pkg::word_t hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready out
    output logic hresp, // response, always okay
    output port_pkg::word_t hrdata, // read data
    input wire port_pkg::byte_t pin_in, // raw pin levels
    output port_pkg::byte_t pin_out, // pad output level
    output port_pkg::byte_t pin_oe_n, // pad drive, low drives
    output port_pkg::byte_t pull_up_en, // pad pull-up enable
    output port_pkg::byte_t pull_down_en // pad pull-down enable
);
    import port_pkg::*;

    // match a word index against a register index
    function automatic logic idx_hit(input logic [29:0] index, input logic [15:0] reg_idx);
        idx_hit = (index == {14'h0000, reg_idx});
    endfunction : idx_hit

    // pad state of one pin from direction, drive pair and data bit
    function automatic pad_ctrl_t pad_decode(
        input logic dir,
        input logic [1:0] code,
        input logic level
    );
        pad_ctrl_t p;
        p = '{level: 1'b0, oe_n: 1'b1, pull_up: 1'b0, pull_down: 1'b0};
        if (dir == DIR_OUT)
        begin
            case (drive_code_t'(code))
                // high-impedance output
                DRV_HIZ:
                begin
                    p.oe_n = 1'b1;
                end
                // p-channel open drain: drives high only
                DRV_PCH_OD:
                begin
                    p.level = 1'b1;
                    p.oe_n = ~level;
                end
                // n-channel open drain: drives low only
                DRV_NCH_OD:
                begin
                    p.level = 1'b0;
                    p.oe_n = level;
                end
                // cmos: drives both levels
                default:
                begin
                    p.level = level;
                    p.oe_n = 1'b0;
                end
            endcase
        end
        else
        begin
            // input: pad released, pulls per code
            p.pull_down = (drive_code_t'(code) == DRV_PCH_OD);
            p.pull_up = (drive_code_t'(code) == DRV_NCH_OD);
        end
        pad_decode = p;
    endfunction : pad_decode

    // next value of one byte register: written byte or held value
    function automatic byte_t byte_next(input logic hit, input byte_t wd, input byte_t cur);
        byte_next = hit ? wd : cur;
    endfunction : byte_next

    // next value of an upper byte: wide write below it, own write, or hold
    function automatic byte_t upper_next(
        input logic wide_hit,
        input logic own_hit,
        input byte_t wd_hi,
        input byte_t wd_lo,
        input byte_t cur
    );
        if (wide_hit)
        begin
            upper_next = wd_hi;
        end
        else if (own_hit)
        begin
            upper_next = wd_lo;
        end
        else
        begin
            upper_next = cur;
        end
    endfunction : upper_next

    // read word with one byte in bits 7:0, upper bits zero
    function automatic word_t byte_word(input byte_t b);
        byte_word = {24'h000000, b};
    endfunction : byte_word

    // read word with a byte pair in bits 15:0, upper bits zero
    function automatic word_t pair_word(input byte_t hi, input byte_t lo);
        pair_word = {16'h0000, hi, lo};
    endfunction : pair_word

    // stored registers
    byte_t data_r; // pin data
    byte_t dir_r; // pin direction
    byte_t drv_low_r; // drive select bit 0 per pin
    byte_t drv_high_r; // drive select bit 1 per pin
    byte_t fsel_low_r; // function select low byte
    byte_t fsel_high_r; // function select high byte
    addr_phase_t aph_r; // pending data phase

    // next values
    byte_t data_nxt;
    byte_t dir_nxt;
    byte_t drv_low_nxt;
    byte_t drv_high_nxt;
    byte_t fsel_low_nxt;
    byte_t fsel_high_nxt;
    addr_phase_t aph_nxt;
    word_t hrdata_nxt;

    // synchronised pin levels
    byte_t pin_sync;

    // pad control per pin
    pad_ctrl_t pad_nxt [PORT_W];
    byte_t pin_out_nxt;
    byte_t pin_oe_n_nxt;
    byte_t pull_up_nxt;
    byte_t pull_down_nxt;

    // input synchroniser for all pins
    // raw pins are asynchronous; nothing here reads them before the second flop
    pin_sync #(
        .WIDTH(PORT_W)
    ) pin_sync_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // address phase is taken when selected, ready and nonseq
    // hready keeps a phase stalled by another slave from being taken twice
    wire take = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire [29:0] a_index = haddr[31:2];

    // capture of the address phase for the write in the data phase
    assign aph_nxt.valid = take & hwrite;
    assign aph_nxt.write = hwrite;
    assign aph_nxt.wide = (hsize != HSIZE_BYTE);
    assign aph_nxt.index = a_index;

    // write decode in the data phase
    wire wr = aph_r.valid;
    wire wr_wide = aph_r.wide;
    wire wr_data = wr & idx_hit(aph_r.index, IDX_PIN_DATA);
    wire wr_dir = wr & idx_hit(aph_r.index, IDX_PIN_DIR);
    wire wr_drv_lo = wr & idx_hit(aph_r.index, IDX_DRV_LOW);
    wire wr_drv_hi = wr & idx_hit(aph_r.index, IDX_DRV_HIGH);
    wire wr_fs_lo = wr & idx_hit(aph_r.index, IDX_FSEL_LOW);
    wire wr_fs_hi = wr & idx_hit(aph_r.index, IDX_FSEL_HIGH);
    wire [7:0] wd_lo = hwdata[7:0];
    wire [7:0] wd_hi = hwdata[15:8];

    // data register keeps every written value
    assign data_nxt = byte_next(wr_data, wd_lo, data_r);

    // direction register
    assign dir_nxt = byte_next(wr_dir, wd_lo, dir_r);

    // low drive byte: byte or word write at the lower index
    assign drv_low_nxt = byte_next(wr_drv_lo, wd_lo, drv_low_r);

    // high drive byte: own index, or bits 15:8 of a wide write below it
    assign drv_high_nxt = upper_next(wr_drv_lo & wr_wide, wr_drv_hi, wd_hi, wd_lo,
        drv_high_r);

    // function select bytes pair the same way
    assign fsel_low_nxt = byte_next(wr_fs_lo, wd_lo, fsel_low_r);
    assign fsel_high_nxt = upper_next(wr_fs_lo & wr_wide, wr_fs_hi, wd_hi, wd_lo, fsel_high_r);

    // read decode from the live address phase
    wire rd = take & ~hwrite;
    wire rd_data = rd & idx_hit(a_index, IDX_PIN_DATA);
    wire rd_dir = rd & idx_hit(a_index, IDX_PIN_DIR);
    wire rd_drv_lo = rd & idx_hit(a_index, IDX_DRV_LOW);
    wire rd_drv_hi = rd & idx_hit(a_index, IDX_DRV_HIGH);
    wire rd_fs_lo = rd & idx_hit(a_index, IDX_FSEL_LOW);
    wire rd_fs_hi = rd & idx_hit(a_index, IDX_FSEL_HIGH);

    // input pins show the pin level, output pins the stored bit
    wire [7:0] data_view = (dir_nxt & pin_sync) | (~dir_nxt & data_nxt);

    // read mux; next values forward a write still in its data phase
    always_comb
    begin
        if (rd_data)
        begin
            hrdata_nxt = byte_word(data_view);
        end
        else if (rd_dir)
        begin
            hrdata_nxt = byte_word(dir_nxt);
        end
        else if (rd_drv_lo)
        begin
            // lower index reads the whole 16-bit drive word
            hrdata_nxt = pair_word(drv_high_nxt, drv_low_nxt);
        end
        else if (rd_drv_hi)
        begin
            hrdata_nxt = byte_word(drv_high_nxt);
        end
        else if (rd_fs_lo)
        begin
            hrdata_nxt = pair_word(fsel_high_nxt, fsel_low_nxt);
        end
        else if (rd_fs_hi)
        begin
            hrdata_nxt = byte_word(fsel_high_nxt);
        end
        else
        begin
            // unmapped address or no read: zero
            hrdata_nxt = RST_RDATA;
        end
    end

    // pad decode for each pin
    always_comb
    begin
        for (int i = 0; i < PORT_W; i++)
        begin
            pad_nxt[i] = pad_decode(dir_nxt[i], {drv_high_nxt[i], drv_low_nxt[i]},
                data_nxt[i]);
            pin_out_nxt[i] = pad_nxt[i].level;
            pin_oe_n_nxt[i] = pad_nxt[i].oe_n;
            pull_up_nxt[i] = pad_nxt[i].pull_up;
            pull_down_nxt[i] = pad_nxt[i].pull_down;
        end
    end

    // data and direction registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            data_r <= RST_PIN_DATA;
            dir_r <= RST_PIN_DIR;
        end
        else
        begin
            data_r <= data_nxt;
            dir_r <= dir_nxt;
        end
    end

    // drive-control byte pair
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            drv_low_r <= RST_DRV;
            drv_high_r <= RST_DRV;
        end
        else
        begin
            drv_low_r <= drv_low_nxt;
            drv_high_r <= drv_high_nxt;
        end
    end

    // function select byte pair, stored only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fsel_low_r <= RST_FSEL;
            fsel_high_r <= RST_FSEL;
        end
        else
        begin
            fsel_low_r <= fsel_low_nxt;
            fsel_high_r <= fsel_high_nxt;
        end
    end

    // bus side flops: pending phase and answer
    // hrdata falls back to zero when no read is taken, so stale data never lingers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            aph_r <= '0;
            hrdata <= RST_RDATA;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
        else
        begin
            aph_r <= aph_nxt;
            hrdata <= hrdata_nxt;
            // never stalls, always okay
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // pad outputs; reset state is high-impedance output
    // built from next values so pads change at the edge where the write lands
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_out <= RST_PAD_LEVEL;
            pin_oe_n <= RST_PAD_OE_N;
            pull_up_en <= RST_PULL;
            pull_down_en <= RST_PULL;
        end
        else
        begin
            pin_out <= pin_out_nxt;
            pin_oe_n <= pin_oe_n_nxt;
            pull_up_en <= pull_up_nxt;
            pull_down_en <= pull_down_nxt;
        end
    end

endmodule : port_io

// file: rtl/port_pkg.sv
// package of constants and types for the 8-bit port data/direction block
package port_pkg;

    // bus word and port byte
    typedef logic [31:0] word_t;
    typedef logic [7:0] byte_t;

    // port width
    localparam int PORT_W = 8;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_PIN_DATA = 16'hF228;
    localparam logic [15:0] IDX_PIN_DIR = 16'hF229;
    localparam logic [15:0] IDX_DRV_LOW = 16'hF22A;
    localparam logic [15:0] IDX_DRV_HIGH = 16'hF22B;
    localparam logic [15:0] IDX_FSEL_LOW = 16'hF22C;
    localparam logic [15:0] IDX_FSEL_HIGH = 16'hF22D;

    // reset values of every register
    localparam byte_t RST_PIN_DATA = 8'h00;
    localparam byte_t RST_PIN_DIR = 8'h00;
    localparam byte_t RST_DRV = 8'h00;
    localparam byte_t RST_FSEL = 8'h00;
    localparam word_t RST_RDATA = 32'h0000_0000;

    // pads after reset: released, no pulls
    localparam byte_t RST_PAD_LEVEL = 8'h00;
    localparam byte_t RST_PAD_OE_N = 8'hFF;
    localparam byte_t RST_PULL = 8'h00;

    // ahb transfer and size codes
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic HRESP_OKAY = 1'b0;

    // synchroniser depth on pin inputs
    localparam int SYNC_STAGES = 2;

    // direction bit meaning
    localparam logic DIR_OUT = 1'b0;
    localparam logic DIR_IN = 1'b1;

    // drive-control pair codes per pin
    typedef enum logic [1:0] {
        DRV_HIZ = 2'h0,
        DRV_PCH_OD = 2'h1,
        DRV_NCH_OD = 2'h2,
        DRV_CMOS = 2'h3
    } drive_code_t;

    // captured address phase of one transfer
    typedef struct packed {
        logic valid;
        logic write;
        logic wide;
        logic [29:0] index;
    } addr_phase_t;

    // per-pin pad control bundle
    typedef struct packed {
        logic level;
        logic oe_n;
        logic pull_up;
        logic pull_down;
    } pad_ctrl_t;

endpackage : port_pkg

// file: rtl/pin_sync.sv
// two-flop synchroniser for the port input pins
module pin_sync
    import port_pkg::*;
#(
    parameter int WIDTH = PORT_W
)
(
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // raw pin levels
    output logic [WIDTH-1:0] sync_out // levels safe to use
);

    // first stage, read only by the second stage
    logic [WIDTH-1:0] meta_r;

    // two flops in series, cleared on reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : pin_sync

// file: test/pad_model.sv
// far side of the port: external drivers, pull resistors, floating pins
module pad_model
(
    input wire logic hclk, // paces floating pins
    input wire port_pkg::byte_t pin_out, // device level
    input wire port_pkg::byte_t pin_oe_n, // low drives
    input wire port_pkg::byte_t pull_up_en, // pull-ups
    input wire port_pkg::byte_t pull_down_en, // pull-downs
    input wire port_pkg::byte_t ext_en, // external drive on
    input wire port_pkg::byte_t ext_level, // external level
    output port_pkg::byte_t pin_lvl // wire level
);
    timeunit 1ns;
    timeprecision 1ps;
    import port_pkg::*;
    byte_t flt_r = 8'h5A; // undriven pins toggle, never stale
    // floating level flips every cycle
    always @(posedge hclk)
        flt_r <= ~flt_r;
    // device, then external driver, then pulls
    always_comb
        for (int i = 0; i < 8; i++)
            pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_level[i] :
                pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : flt_r[i];
endmodule : pad_model

// file: test/port_io_checker.sv
// bus and pad checks on the port block
module port_io_checker
(
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire logic hsel, // select
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic hready, // ready in
    input wire logic hreadyout, // ready out
    input wire logic hresp, // response
    input wire port_pkg::word_t hrdata, // read data
    input wire port_pkg::byte_t pin_out, // pad level
    input wire port_pkg::byte_t pin_oe_n, // low drives
    input wire port_pkg::byte_t pull_up_en, // pull-ups
    input wire port_pkg::byte_t pull_down_en // pull-downs
);
    timeunit 1ns;
    timeprecision 1ps;
    import port_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a read taken in its address phase
    sequence s_rd;
        hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    endsequence
    property p_ready; hreadyout == 1'b1; endproperty
    property p_okay; hresp == HRESP_OKAY; endproperty
    property p_idle_rd;
        !(hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) |=> hrdata == RST_RDATA;
    endproperty
    property p_rd_upper; s_rd |=> hrdata[31:16] == 16'h0000; endproperty
    property p_pad_cause;
        $changed({pin_out, pin_oe_n, pull_up_en, pull_down_en})
            |-> $past(hsel && hready && htrans == HTRANS_NONSEQ && hwrite, 2);
    endproperty
    property p_drv_nopull; (~pin_oe_n & (pull_up_en | pull_down_en)) == 8'h00; endproperty
    property p_pull_excl; (pull_up_en & pull_down_en) == 8'h00; endproperty
    property p_pull_low; ((pull_up_en | pull_down_en) & pin_out) == 8'h00; endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    a_okay: assert property (p_okay) else $error("bad response");
    a_idle_rd: assert property (p_idle_rd) else $error("stray read data");
    a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
    a_pad_cause: assert property (p_pad_cause) else $error("pad moved unasked");
    a_drv_nopull: assert property (p_drv_nopull) else $error("pull on driven pin");
    a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
    a_pull_low: assert property (p_pull_low) else $error("input pin level");
endmodule : port_io_checker

bind port_io port_io_checker port_io_checker_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));

// file: test/tb_port_io.sv
// self-checking bench for the port data and direction block
module tb_port_io;
    timeunit 1ns;
    timeprecision 1ps;
    import port_pkg::*;
    localparam word_t A_DATA = {14'h0, IDX_PIN_DATA, 2'b00}; // data
    localparam word_t A_DIR = {14'h0, IDX_PIN_DIR, 2'b00}; // direction
    localparam word_t A_DRV = {14'h0, IDX_DRV_LOW, 2'b00}; // drive word
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp; // bus controls
    logic [1:0] htrans; // transfer type
    logic [2:0] hsize; // transfer size
    word_t haddr, hwdata, hrdata; // bus address and data
    byte_t pin_in, pin_out, pin_oe_n, pull_up_en, pull_down_en; // pads
    byte_t ext_en, ext_level, d, m, x; // far-side drive, test data
    logic [15:0] e; // drive code pair
    word_t exp_q[$]; // expected read data
    logic rd_taken = 1'b0; // read address taken last edge
    int n_mismatch = 0;
    int checked = 0;
    port_io port_io_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));
    pad_model pad_model_inst (.hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en),
        .ext_level(ext_level), .pin_lvl(pin_in));
    // clock
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // verdict and end of run
    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // compare one read word
    task automatic cmp_rd(input word_t got, input word_t exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t read got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_rd
    // compare one pad state word
    task automatic cmp_pad(input word_t got, input word_t exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t pads got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_pad
    // one single word transfer; reads note their expected data
    task automatic ahb(input word_t a, input logic w, input word_t wd, input word_t ex);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= wd;
        if (!w)
            exp_q.push_back(ex);
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : ahb
    // pad state: driven level, drive enables, pulls
    task automatic pads(input byte_t lv, input byte_t oe, input byte_t pu, input byte_t pd);
        @(posedge hclk);
        cmp_pad({pin_out & ~pin_oe_n, pin_oe_n, pull_up_en, pull_down_en},
            {lv, oe, pu, pd});
    endtask : pads
    // read data watcher
    always @(posedge hclk)
    begin
        if (rd_taken === 1'b1)
            cmp_rd(hrdata, exp_q.pop_front());
        rd_taken = hresetn && hsel && htrans == HTRANS_NONSEQ && !hwrite;
    end
    // watchdog
    initial
    begin
        repeat (5000) @(posedge hclk);
        n_mismatch++;
        end_of_test();
    end
    // main sequence
    initial
    begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata, ext_en, ext_level} = '0;
        hsize = 3'h2;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        void'($urandom(88450));
        @(posedge hclk);
        // reset values, last one unmapped
        for (int k = 0; k < 7; k++)
            ahb(A_DATA + 32'(4 * k), 1'b0, 32'h0, RST_RDATA);
        pads(8'h00, 8'hFF, 8'h00, 8'h00);
        // cmos outputs with random data and directions
        repeat (4)
        begin
            d = 8'($urandom);
            m = 8'($urandom);
            x = 8'($urandom);
            ahb(A_DRV, 1'b1, 32'hFFFF, 0);
            ahb(A_DATA, 1'b1, {24'h0, d}, 0);
            ahb(A_DIR, 1'b1, {24'h0, m}, 0);
            ext_en <= m;
            ext_level <= x;
            ahb(A_DIR, 1'b0, 0, {24'h0, m});
            pads(d & ~m, m, 8'h00, 8'h00);
            repeat (2) @(posedge hclk);
            ahb(A_DATA, 1'b0, 0, {24'h0, (d & ~m) | (x & m)});
        end
        ext_en <= 8'h00;
        // every drive code, output then input mode
        for (int c = 0; c < 4; c++)
        begin
            e = {{8{c[1]}}, {8{c[0]}}};
            ahb(A_DRV, 1'b1, {16'h0, e}, 0);
            ahb(A_DIR, 1'b1, 0, 0);
            ahb(A_DRV, 1'b0, 0, {16'h0, e});
            pads(c[0] ? d : 8'h00, c[0] ? (c[1] ? 8'h00 : ~d) : (c[1] ? d : 8'hFF), 0, 0);
            ahb(A_DIR, 1'b1, 32'hFF, 0);
            pads(8'h00, 8'hFF, e[15:8] & ~e[7:0], e[7:0] & ~e[15:8]);
            if (c == 1 || c == 2)
            begin
                // pulls reach the read path only after the two-flop synchroniser
                repeat (2) @(posedge hclk);
                ahb(A_DATA, 1'b0, 0, {24'h0, {8{c[1]}}});
            end
        end
        // high drive byte by its own index; pins still in input mode
        x = 8'($urandom);
        ahb(A_DRV + 32'h4, 1'b1, {24'h0, x}, 0);
        ahb(A_DRV, 1'b0, 0, {16'h0, x, 8'hFF});
        ahb(A_DRV + 32'h4, 1'b0, 0, {24'h0, x});
        pads(8'h00, 8'hFF, 8'h00, ~x);
        // function select pair written as one wide word
        ahb(A_DATA + 32'h10, 1'b1, {16'h0, m, d}, 0);
        ahb(A_DATA + 32'h10, 1'b0, 0, {16'h0, m, d});
        ahb(A_DATA + 32'h14, 1'b0, 0, {24'h0, m});
        repeat (2) @(posedge hclk);
        end_of_test();
    end
endmodule : tb_port_io
